// ---- pkg/hpcc_arb_if.sv ----
// Request and grant bundle between the cycle front end and the memory arbiter.
// Assumes all signals are on mclk.
`timescale 1ns/1ps
interface hpcc_arb_if;
  logic [hpcc_pkg::NUM_BLK-1:0] cpu_req;
  logic                         hp_req;
  logic [hpcc_pkg::BLK_W-1:0]   hp_blk;
  logic                         hp_gnt;
  logic                         dma_req;
  logic [hpcc_pkg::BLK_W-1:0]   dma_blk;
  logic                         dma_gnt;
  modport top (output cpu_req, hp_req, hp_blk, dma_req, dma_blk, input hp_gnt, dma_gnt);
  modport arb (input cpu_req, hp_req, hp_blk, dma_req, dma_blk, output hp_gnt, dma_gnt);
endinterface : hpcc_arb_if

// ---- pkg/hpcc_pkg.sv ----
// Constants, cycle-type codes and state encoding for the host port cycle front end.
// Assumes one 200 MHz clock (mclk) and a synchronous active-high reset.
// How it works
// - Wide mode: data access at once, address bus
// - Wide mode uses low 15 address bits only
// - Ready low while memory path is busy
// - Control latched on address strobe (byte mode only) or strobe start
// - Read fetches word at read address first
// - Write data taken at strobe end, then stored
// - Core beats host path on same block
// - Host path and system DMA alternate per half
// - Data strobes ignored while port is deselected
// - Ready forced high while port is deselected
// - Access codes: control, data+inc, address, data
// - Wide mode: only control and plain data valid
// - Single address mode: both registers move together
// - Dual address mode: select bit picks register
// - Strap at reset: low wide, high byte
package hpcc_pkg;
  // =====================================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 16;
  localparam int MEM_AW  = 15;
  localparam int NUM_BLK = 8;
  localparam int BLK_W   = 3;
  // =====================================================================
  // Access type codes
  localparam logic [1:0] AT_CTRL     = 2'h0;
  localparam logic [1:0] AT_DATA_INC = 2'h1;
  localparam logic [1:0] AT_ADDR     = 2'h2;
  localparam logic [1:0] AT_DATA     = 2'h3;
  // =====================================================================
  // Control register fields and reset values
  localparam int CTRL_BOB_BIT     = 0;
  localparam int CTRL_DUAL_BIT    = 3;
  localparam int CTRL_SEL_BIT     = 4;
  localparam int CTRL_BOBSTAT_BIT = 8;
  localparam logic        CTRL_BOB_RST  = 1'h0;
  localparam logic        CTRL_DUAL_RST = 1'h0;
  localparam logic        CTRL_SEL_RST  = 1'h0;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [15:0] DATA_RST      = 16'h0000;
  // =====================================================================
  // Cycle state
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ACT   = 5'b00010,
    S_FETCH = 5'b00100,
    S_RDATA = 5'b01000,
    S_STORE = 5'b10000
  } hpcc_state_e;
endpackage : hpcc_pkg

// ---- verification/hpcc_mem_model.sv ----
// Internal memory partner: stores writes, answers reads four cycles after the strobe.
// Assumes one mclk domain and a synchronous active-high reset.
`timescale 1ns/1ps
module hpcc_mem_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Memory port
  input  wire logic        mem_stb,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_rvalid
);
  logic [15:0] mem [0:255];
  logic [14:0] wa;
  logic [15:0] wd;
  logic [7:0]  ra;
  logic [1:0]  dly;
  int          n_acc;
  // =====================================================================
  // Storage and delayed read answer; data toggles while not valid
  always @(posedge mclk) begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (rst) begin
      n_acc     <= 0;
      dly       <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end else begin
      if (dly != 2'h0) dly <= dly - 2'h1;
      if (dly == 2'h1) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= mem[ra];
      end
      if (mem_stb) begin
        n_acc <= n_acc + 1;
        if (mem_we) begin
          mem[mem_addr[7:0]] <= mem_wdata;
          wa <= mem_addr;
          wd <= mem_wdata;
        end else begin
          ra  <= mem_addr[7:0];
          dly <= 2'h3;
        end
      end
    end
  end
endmodule : hpcc_mem_model

// ---- verification/testbench.sv ----
// Self-checking bench: host cycles through the pins, memory answered by the model.
// Assumes one clock; inputs change on the falling edge, outputs are read there too.
`timescale 1ns/1ps
module testbench;
  import hpcc_pkg::*;
  logic mclk = 0, rst = 1, port_select_n = 1, data_strobe_a = 1, data_strobe_b = 1;
  logic addr_strobe_n = 1, dir_sel = 1, byte_id_line = 0, mode_strap_pin = 0;
  logic [1:0]  access_type_sel = 2'h3;
  logic [15:0] host_addr_bus = 0, host_data_in = 0, host_data_out, mem_rdata, mem_wdata, q;
  logic [14:0] mem_addr;
  logic [7:0]  cpu_req = 0;
  logic host_data_oe, host_ready, mem_stb, mem_we, mem_rvalid, mux_mode, saw_low, oe_s;
  logic use_b = 0, dma_on = 0, sys_dma_req = 0, sys_dma_gnt;
  logic [2:0]  sys_dma_blk = 3'h0;
  int errors = 0, n_compared = 0, cyc = 0, n0, n_lo = 0;
  hpcc_top i_dut (.mclk(mclk), .rst(rst), .port_select_n(port_select_n),
    .data_strobe_a(data_strobe_a), .data_strobe_b(data_strobe_b),
    .addr_strobe_n(addr_strobe_n), .access_type_sel(access_type_sel), .dir_sel(dir_sel),
    .byte_id_line(byte_id_line), .host_addr_bus(host_addr_bus), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_ready(host_ready),
    .mode_strap_pin(mode_strap_pin), .mem_stb(mem_stb), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .cpu_req(cpu_req), .sys_dma_req(sys_dma_req),
    .sys_dma_blk(sys_dma_blk), .sys_dma_gnt(sys_dma_gnt), .mux_mode(mux_mode));
  hpcc_mem_model i_mem (.mclk(mclk), .rst(rst), .mem_stb(mem_stb), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid));
  initial forever #2.5 mclk = ~mclk;
  // Cycles in which the system DMA requester is refused
  always @(negedge mclk) begin
    if (dma_on && sys_dma_gnt !== 1'b1) n_lo <= n_lo + 1;
  end
  // =====================================================================
  // Reporting
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  // =====================================================================
  // One host transfer: select, strobe, wait ready, end strobe, wait store
  task automatic hc(input logic [1:0] at, input logic rd, input logic bil,
                    input logic [15:0] a, input logic [15:0] wd);
    int k;
    access_type_sel = at;
    dir_sel = rd;
    byte_id_line = bil;
    host_addr_bus = a;
    host_data_in = wd;
    saw_low = 0;
    port_select_n = 0;
    if (use_b && rd) data_strobe_b = 0;
    else data_strobe_a = 0;
    for (k = 0; k < 6; k++) begin
      @(negedge mclk);
      if (host_ready === 1'b0) saw_low = 1;
    end
    k = 0;
    while (host_ready !== 1'b1 && k < 60) begin @(negedge mclk); k++; end
    q = host_data_out;
    oe_s = host_data_oe;
    data_strobe_a = 1;
    data_strobe_b = 1;
    repeat (6) @(negedge mclk);
    k = 0;
    while (host_ready !== 1'b1 && k < 60) begin @(negedge mclk); k++; end
    chk(k < 60, "ready stuck low");
    port_select_n = 1;
    repeat (2) @(negedge mclk);
  endtask : hc
  task automatic do_reset(input logic strap);
    mode_strap_pin = strap; rst = 1;
    repeat (12) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
  endtask : do_reset
  // =====================================================================
  // Scenarios
  initial begin
    do_reset(1'b0);
    chk(host_ready === 1'b1 && host_data_oe === 1'b0, "reset outputs");
    chk(mux_mode === 1'b0, "wide mode after low strap");
    hc(AT_DATA, 1'b0, 1'b0, 16'h8005, 16'h1234);
    chk(i_mem.wa === 15'h0005 && i_mem.wd === 16'h1234, "wide write");
    hc(AT_DATA, 1'b1, 1'b0, 16'h0005, 16'h0000);
    chk(q === 16'h1234 && oe_s === 1'b1, "wide read data");
    chk(saw_low === 1'b1, "ready low during fetch");
    n0 = i_mem.n_acc;
    data_strobe_a = 0;
    repeat (10) @(negedge mclk);
    chk(i_mem.n_acc == n0, "strobe while deselected");
    chk(host_ready === 1'b1, "ready while deselected");
    data_strobe_a = 1;
    repeat (4) @(negedge mclk);
    cpu_req = 8'h01;
    fork
      hc(AT_DATA, 1'b1, 1'b0, 16'h0005, 16'h0000);
      begin
        repeat (20) @(negedge mclk);
        chk(i_mem.n_acc == n0 && host_ready === 1'b0, "core blocks host");
        cpu_req = 8'h00;
      end
    join
    chk(q === 16'h1234, "read after core");
    n0 = i_mem.n_acc;
    hc(AT_DATA_INC, 1'b0, 1'b0, 16'h0005, 16'hdead);
    chk(i_mem.n_acc == n0, "wide mode ignores increment type");
    use_b = 1;
    sys_dma_req = 1;
    repeat (2) @(negedge mclk);
    dma_on = 1;
    hc(AT_DATA, 1'b1, 1'b0, 16'h0005, 16'h0000);
    hc(AT_DATA, 1'b1, 1'b0, 16'h0005, 16'h0000);
    chk(q === 16'h1234 && n_lo == 2, "host and dma alternate");
    sys_dma_blk = 3'h4;
    hc(AT_DATA, 1'b1, 1'b0, 16'h0005, 16'h0000);
    chk(n_lo == 2, "other half not shared");
    dma_on = 0;
    sys_dma_req = 0;
    use_b = 0;
    do_reset(1'b1);
    chk(mux_mode === 1'b1, "byte mode after high strap");
    hc(AT_CTRL, 1'b0, 1'b0, 16'h0000, 16'h0001);
    hc(AT_ADDR, 1'b0, 1'b0, 16'h0000, 16'h0000);
    hc(AT_ADDR, 1'b0, 1'b1, 16'h0000, 16'h0010);
    hc(AT_DATA_INC, 1'b0, 1'b0, 16'h0000, 16'h00ab);
    hc(AT_DATA_INC, 1'b0, 1'b1, 16'h0000, 16'h00cd);
    chk(i_mem.wa === 15'h0010 && i_mem.wd === 16'habcd, "byte write");
    hc(AT_DATA_INC, 1'b0, 1'b0, 16'h0000, 16'h0012);
    hc(AT_DATA_INC, 1'b0, 1'b1, 16'h0000, 16'h0034);
    chk(i_mem.wa === 15'h0011 && i_mem.wd === 16'h1234, "autoincrement");
    hc(AT_CTRL, 1'b0, 1'b1, 16'h0000, 16'h0019);
    hc(AT_ADDR, 1'b0, 1'b0, 16'h0000, 16'h0000);
    hc(AT_ADDR, 1'b0, 1'b1, 16'h0000, 16'h0010);
    hc(AT_DATA_INC, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(q === 16'h00ab && oe_s === 1'b1 && saw_low === 1'b1, "byte read fetch");
    hc(AT_DATA_INC, 1'b1, 1'b1, 16'h0000, 16'h0000);
    chk(q === 16'h00cd, "byte read second");
    hc(AT_DATA_INC, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(q === 16'h0012, "read address incremented");
    access_type_sel = AT_DATA_INC;
    dir_sel = 1;
    byte_id_line = 1;
    addr_strobe_n = 0;
    repeat (4) @(negedge mclk);
    addr_strobe_n = 1;
    hc(AT_CTRL, 1'b1, 1'b1, 16'h0000, 16'h0000);
    chk(q === 16'h0034, "address strobe latch");
    hc(AT_DATA, 1'b0, 1'b0, 16'h0000, 16'h0055);
    hc(AT_DATA, 1'b0, 1'b1, 16'h0000, 16'h0066);
    chk(i_mem.wa === 15'h0012 && i_mem.wd === 16'h5566, "dual keeps write address");
    stop_test();
  end
endmodule : testbench

// ---- verilog/hpcc_arb.sv ----
// Dual-access memory arbiter: core first, host path and system DMA alternate.
// Assumes requests are held until granted; grant is a same-cycle level.
`timescale 1ns/1ps
module hpcc_arb (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request bundle
  hpcc_arb_if.arb  bus
);
  import hpcc_pkg::*;

  logic [1:0] turn_dma;
  logic [1:0] next_turn_dma;
  logic       hp_free;
  logic       dma_free;
  logic       clash;
  logic       half;

  // =====================================================================
  // Grant decision
  always_comb begin
    hp_free       = bus.hp_req & ~bus.cpu_req[bus.hp_blk];
    dma_free      = bus.dma_req & ~bus.cpu_req[bus.dma_blk];
    half          = bus.hp_blk[BLK_W-1];
    clash         = hp_free & dma_free & (half == bus.dma_blk[BLK_W-1]);
    bus.hp_gnt    = hp_free & ~(clash & turn_dma[half]);
    bus.dma_gnt   = dma_free & ~(clash & ~turn_dma[half]);
    next_turn_dma = turn_dma;
    if (clash) begin
      next_turn_dma[half] = ~turn_dma[half];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      turn_dma <= 2'h0;
    end else begin
      turn_dma <= next_turn_dma;
    end
  end

  chk_core_wins_hp: assert property (@(posedge mclk) disable iff (rst)
    (bus.hp_req && bus.cpu_req[bus.hp_blk]) |-> !bus.hp_gnt)
    else $error("host path granted over core");
  chk_rr_alternate: assert property (@(posedge mclk) disable iff (rst)
    clash ##1 (clash && half == $past(half))
    |-> bus.hp_gnt != $past(bus.hp_gnt) && bus.dma_gnt != $past(bus.dma_gnt))
    else $error("round robin did not alternate");
endmodule : hpcc_arb

// ---- verilog/hpcc_top.sv ----
// Host port cycle front end: strobe derivation, control latch, cycle decode,
// data flow to internal memory and ready gating.
// Assumes host pins are asynchronous; memory and core requests are on mclk.
`timescale 1ns/1ps
module hpcc_top #(
  parameter int MEM_AW = hpcc_pkg::MEM_AW
) (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst,
  // Host pins
  input  wire logic                           port_select_n,
  input  wire logic                           data_strobe_a,
  input  wire logic                           data_strobe_b,
  input  wire logic                           addr_strobe_n,
  input  wire logic [1:0]                     access_type_sel,
  input  wire logic                           dir_sel,
  input  wire logic                           byte_id_line,
  input  wire logic [hpcc_pkg::ADDR_W-1:0]    host_addr_bus,
  input  wire logic [hpcc_pkg::DATA_W-1:0]    host_data_in,
  output logic      [hpcc_pkg::DATA_W-1:0]    host_data_out,
  output logic                                host_data_oe,
  output logic                                host_ready,
  input  wire logic                           mode_strap_pin,
  // Internal memory port
  output logic                                mem_stb,
  output logic                                mem_we,
  output logic      [MEM_AW-1:0]              mem_addr,
  output logic      [hpcc_pkg::DATA_W-1:0]    mem_wdata,
  input  wire logic [hpcc_pkg::DATA_W-1:0]    mem_rdata,
  input  wire logic                           mem_rvalid,
  // Competing requesters
  input  wire logic [hpcc_pkg::NUM_BLK-1:0]   cpu_req,
  input  wire logic                           sys_dma_req,
  input  wire logic [hpcc_pkg::BLK_W-1:0]     sys_dma_blk,
  output logic                                sys_dma_gnt,
  // Status
  output logic                                mux_mode
);
  import hpcc_pkg::*;

  if (MEM_AW < BLK_W + 1 || MEM_AW >= ADDR_W) begin : g_bad_aw
    $error("MEM_AW must lie between BLK_W+1 and ADDR_W-1");
  end

  // =====================================================================
  // Helpers
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic bil,
                                           input logic order);
    pick_byte = (bil == order) ? w[7:0] : w[15:8];
  endfunction : pick_byte

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic [7:0] b,
                                           input logic bil, input logic order);
    put_byte = (bil == order) ? {w[15:8], b} : {b, w[7:0]};
  endfunction : put_byte

  function automatic logic [BLK_W-1:0] blk_of(input logic [MEM_AW-1:0] a);
    blk_of = a[MEM_AW-1 -: BLK_W];
  endfunction : blk_of

  // =====================================================================
  // Pin synchronisers
  logic [8:0]        pin_s1;
  logic [8:0]        pin_s2;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [DATA_W-1:0] din_s1;
  logic [DATA_W-1:0] din_s2;

  always_ff @(posedge mclk) begin
    pin_s1  <= {port_select_n, data_strobe_a, data_strobe_b, addr_strobe_n,
                access_type_sel, dir_sel, byte_id_line, mode_strap_pin};
    pin_s2  <= pin_s1;
    addr_s1 <= host_addr_bus;
    addr_s2 <= addr_s1;
    din_s1  <= host_data_in;
    din_s2  <= din_s1;
  end

  logic       cs_n_s;
  logic       has_n_s;
  logic       strap_s;
  logic [3:0] ctl_pins;
  logic       stb;

  assign cs_n_s   = pin_s2[8];
  assign has_n_s  = pin_s2[5];
  assign ctl_pins = pin_s2[4:1];
  assign strap_s  = pin_s2[0];
  assign stb      = ~cs_n_s & (pin_s2[7] ^ pin_s2[6]);

  // =====================================================================
  // State
  hpcc_state_e       state,      next_state;
  logic              cyc_open,   next_cyc_open;
  logic              has_q,      next_has_q;
  logic              has_valid,  next_has_valid;
  logic [3:0]        has_lat,    next_has_lat;
  logic [3:0]        ctl,        next_ctl;
  logic              byte_order,        next_bob;
  logic              dual,       next_dual;
  logic              sel,        next_sel;
  logic [ADDR_W-1:0] read_addr,  next_read_addr;
  logic [ADDR_W-1:0] write_addr, next_write_addr;
  logic [ADDR_W-1:0] lat_addr,   next_lat_addr;
  logic [DATA_W-1:0] data_reg,   next_data_reg;
  logic [DATA_W-1:0] next_host_data_out;
  logic              next_host_data_oe;
  logic              next_host_ready;
  logic              next_mem_stb;
  logic              next_mem_we;
  logic [MEM_AW-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic [3:0]        cur_ctl;
  logic [15:0]       ctrl_word;
  logic [15:0]       cw;
  logic [15:0]       rd_word;
  logic [MEM_AW-1:0] tgt;
  logic              hp_req_c;
  logic              take;
  logic              wr;
  logic              last;

  hpcc_arb_if arb_bus ();

  hpcc_arb u_arb (
    .mclk (mclk),
    .rst  (rst),
    .bus  (arb_bus)
  );

  assign arb_bus.cpu_req = cpu_req;
  assign arb_bus.hp_req  = hp_req_c;
  assign arb_bus.hp_blk  = blk_of(tgt);
  assign arb_bus.dma_req = sys_dma_req;
  assign arb_bus.dma_blk = sys_dma_blk;

  // Byte mode uses the address registers; wide mode the latched bus address
  assign tgt = !mux_mode ? lat_addr[MEM_AW-1:0] :
               (state == S_STORE) ? write_addr[MEM_AW-1:0] : read_addr[MEM_AW-1:0];

  always_comb begin
    ctrl_word                   = 16'h0000;
    ctrl_word[CTRL_BOB_BIT]     = byte_order;
    ctrl_word[CTRL_BOBSTAT_BIT] = byte_order;
    ctrl_word[CTRL_DUAL_BIT]    = dual;
    ctrl_word[CTRL_SEL_BIT]     = sel;
  end

  // =====================================================================
  // Next-state logic
  always_comb begin
    next_state      = state;
    next_cyc_open   = cyc_open & stb;
    next_has_q      = has_n_s;
    next_has_valid  = has_valid;
    next_has_lat    = has_lat;
    next_ctl        = ctl;
    next_bob        = byte_order;
    next_dual       = dual;
    next_sel        = sel;
    next_read_addr  = read_addr;
    next_write_addr = write_addr;
    next_lat_addr   = lat_addr;
    next_data_reg   = data_reg;
    next_mem_stb    = 1'b0;
    next_mem_we     = mem_we;
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    hp_req_c        = 1'b0;
    cw              = 16'h0000;
    wr              = ~ctl[1];
    last            = ~mux_mode | ctl[0];
    take            = (state == S_IDLE) & stb & ~cyc_open;
    cur_ctl         = (mux_mode & has_valid) ? has_lat : ctl_pins;
    if (mux_mode && has_q && !has_n_s) begin
      next_has_lat   = ctl_pins;
      next_has_valid = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (take) begin
          next_cyc_open  = 1'b1;
          next_ctl       = cur_ctl;
          next_has_valid = 1'b0;
          next_lat_addr  = addr_s2;
          // Read data needs a fetch: wide plain read or first byte in byte mode
          if (cur_ctl[1] && cur_ctl[2] && (mux_mode ? !cur_ctl[0] : cur_ctl[3])) begin
            next_state = S_FETCH;
          end else begin
            next_state = S_ACT;
          end
        end
      end
      S_FETCH: begin
        hp_req_c = 1'b1;
        if (arb_bus.hp_gnt) begin
          next_mem_stb  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = tgt;
          next_state    = S_RDATA;
        end
      end
      S_RDATA: begin
        if (mem_rvalid) begin
          next_data_reg = mem_rdata;
          next_state    = S_ACT;
        end
      end
      S_ACT: begin
        if (!stb) begin
          next_state = S_IDLE;
          case (ctl[3:2])
            AT_CTRL: begin
              if (wr) begin
                cw = mux_mode ? put_byte(ctrl_word, din_s2[7:0], ctl[0], byte_order) : din_s2;
                next_bob  = cw[CTRL_BOB_BIT];
                next_dual = cw[CTRL_DUAL_BIT];
                next_sel  = cw[CTRL_SEL_BIT];
              end
            end
            AT_ADDR: begin
              if (wr && mux_mode) begin
                if (!dual || sel) begin
                  next_read_addr = put_byte(read_addr, din_s2[7:0], ctl[0], byte_order);
                end
                if (!dual || !sel) begin
                  next_write_addr = put_byte(write_addr, din_s2[7:0], ctl[0], byte_order);
                end
              end
            end
            default: begin
              if (mux_mode || ctl[3]) begin
                if (wr) begin
                  next_data_reg = mux_mode ? put_byte(data_reg, din_s2[7:0], ctl[0], byte_order)
                                           : din_s2;
                  if (last) begin
                    next_state = S_STORE;
                  end
                end else if (last && !ctl[3]) begin
                  next_read_addr = read_addr + 16'h0001;
                  if (!dual) begin
                    next_write_addr = write_addr + 16'h0001;
                  end
                end
              end
            end
          endcase
        end
      end
      S_STORE: begin
        hp_req_c = 1'b1;
        if (arb_bus.hp_gnt) begin
          next_mem_stb   = 1'b1;
          next_mem_we    = 1'b1;
          next_mem_addr  = tgt;
          next_mem_wdata = data_reg;
          next_state     = S_IDLE;
          if (mux_mode && ctl[3:2] == AT_DATA_INC) begin
            next_write_addr = write_addr + 16'h0001;
            if (!dual) begin
              next_read_addr = read_addr + 16'h0001;
            end
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    case (next_ctl[3:2])
      AT_CTRL: rd_word = ctrl_word;
      AT_ADDR: rd_word = mux_mode ? ((dual && !sel) ? write_addr : read_addr) : 16'h0000;
      AT_DATA: rd_word = next_data_reg;
      default: rd_word = mux_mode ? next_data_reg : 16'h0000;
    endcase
    next_host_data_out = mux_mode ? {8'h00, pick_byte(rd_word, next_ctl[0], byte_order)} : rd_word;
    next_host_data_oe  = (next_state == S_ACT) & next_ctl[1];
    next_host_ready    = cs_n_s |
                         ~(next_state inside {S_FETCH, S_RDATA, S_STORE});
  end

  // =====================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state         <= S_IDLE;
      cyc_open      <= 1'b0;
      has_q         <= 1'b1;
      has_valid     <= 1'b0;
      has_lat       <= 4'h0;
      ctl           <= 4'h0;
      byte_order           <= CTRL_BOB_RST;
      dual          <= CTRL_DUAL_RST;
      sel           <= CTRL_SEL_RST;
      read_addr     <= ADDR_RST;
      write_addr    <= ADDR_RST;
      lat_addr      <= ADDR_RST;
      data_reg      <= DATA_RST;
      host_data_out <= DATA_RST;
      host_data_oe  <= 1'b0;
      host_ready    <= 1'b1;
      mem_stb       <= 1'b0;
      mem_we        <= 1'b0;
      mem_addr      <= '0;
      mem_wdata     <= DATA_RST;
      sys_dma_gnt   <= 1'b0;
      mux_mode      <= strap_s;
    end else begin
      state         <= next_state;
      cyc_open      <= next_cyc_open;
      has_q         <= next_has_q;
      has_valid     <= next_has_valid;
      has_lat       <= next_has_lat;
      ctl           <= next_ctl;
      byte_order           <= next_bob;
      dual          <= next_dual;
      sel           <= next_sel;
      read_addr     <= next_read_addr;
      write_addr    <= next_write_addr;
      lat_addr      <= next_lat_addr;
      data_reg      <= next_data_reg;
      host_data_out <= next_host_data_out;
      host_data_oe  <= next_host_data_oe;
      host_ready    <= next_host_ready;
      mem_stb       <= next_mem_stb;
      mem_we        <= next_mem_we;
      mem_addr      <= next_mem_addr;
      mem_wdata     <= next_mem_wdata;
      sys_dma_gnt   <= arb_bus.dma_gnt;
    end
  end

  // =====================================================================
  // Checks
  chk_ready_cs_gate: assert property (@(posedge mclk) disable iff (rst)
    cs_n_s |=> host_ready)
    else $error("ready low while deselected");
  chk_ready_busy: assert property (@(posedge mclk) disable iff (rst)
    (state inside {S_FETCH, S_RDATA, S_STORE} && !$past(cs_n_s)) |-> !host_ready)
    else $error("ready high while busy");
  chk_no_take_unsel: assert property (@(posedge mclk) disable iff (rst)
    (state == S_IDLE && cs_n_s) |=> state == S_IDLE)
    else $error("cycle started while deselected");
  chk_strobe_take: assert property (@(posedge mclk) disable iff (rst)
    (state == S_IDLE && stb && !cyc_open) |=> state != S_IDLE && ctl == $past(cur_ctl))
    else $error("strobe start not taken");
  chk_fetch_decode: assert property (@(posedge mclk) disable iff (rst)
    $rose(state == S_FETCH) |-> ctl[2] && ctl[1])
    else $error("fetch for a non data read");
  chk_read_addr_use: assert property (@(posedge mclk) disable iff (rst)
    (mem_stb && !mem_we && mux_mode) |-> mem_addr == read_addr[MEM_AW-1:0])
    else $error("read fetch not at read address");
  chk_write_addr_use: assert property (@(posedge mclk) disable iff (rst)
    (mem_stb && mem_we && mux_mode) |-> mem_addr == $past(write_addr[MEM_AW-1:0]))
    else $error("store not at write address");
  chk_wide_addr: assert property (@(posedge mclk) disable iff (rst)
    (mem_stb && !mux_mode) |-> mem_addr == lat_addr[MEM_AW-1:0])
    else $error("wide mode address mismatch");
  chk_single_inc: assert property (@(posedge mclk) disable iff (rst)
    (state == S_STORE && arb_bus.hp_gnt && mux_mode && !dual && ctl[3:2] == AT_DATA_INC)
    |=> write_addr == $past(write_addr) + 16'h0001 && read_addr == $past(read_addr) + 16'h0001)
    else $error("single mode increment missed");
endmodule : hpcc_top
